// [cfsr_cfg.svh]
// Offsets, field positions, reset values and timing of the fault/status bank
`ifndef CFSR_CFG_SVH
`define CFSR_CFG_SVH

// Register offsets on the internal register port
`define CFSR_OFS_LLOAD 16'h001C
`define CFSR_OFS_CTRL 16'h001D
`define CFSR_OFS_FEVT 16'h0022
`define CFSR_OFS_SEVT 16'h0023
`define CFSR_OFS_FLIVE 16'h0024
`define CFSR_OFS_SLIVE 16'h0025
`define CFSR_OFS_OPST 16'h0026
`define CFSR_OFS_LOG 16'h0027
`define CFSR_OFS_ADDR 16'h0039

// Light-load control fields
`define CFSR_B_STYLE 3
`define CFSR_B_DITHER 1
// Converter control fields
`define CFSR_B_DRN_EN 1
`define CFSR_B_DRN_VAL 0

// Fault event / live fields
`define CFSR_B_FE_OV 7
`define CFSR_B_FE_UV 6
`define CFSR_B_FE_OT 5
`define CFSR_B_FE_OC 4
`define CFSR_B_FE_CB 3
`define CFSR_B_FL_OC 7
`define CFSR_B_FL_OV 6
`define CFSR_B_FL_UV 5
`define CFSR_B_FL_OT 4
`define CFSR_B_FL_CB 3

// System event / live fields
`define CFSR_B_SE_WD 7
`define CFSR_B_SE_RST 6
`define CFSR_B_SE_TMR 2
`define CFSR_B_SE_FLYCAP 1
`define CFSR_B_SE_PG 0

// Operating state fields
`define CFSR_B_OP_PIN 7
`define CFSR_B_OP_MUL 6
`define CFSR_B_OP_EN 5
`define CFSR_B_OP_SW 4
`define CFSR_B_OP_DIR 3

// Address register fields
`define CFSR_B_TO_EN 7
`define CFSR_ADDR_MSB 6

// Implemented bits of the flag registers
`define CFSR_FEVT_MASK 8'hF8
`define CFSR_SEVT_MASK 8'hC7

// Reset values
`define CFSR_RST_FEVT 8'h00
`define CFSR_RST_SEVT 8'h40
`define CFSR_RST_ADDR 7'h70
`define CFSR_RST_BYTE 8'h00
`define CFSR_PG_ALL_OK 2'h3

// First-event codes
`define CFSR_LOG_NONE 5'h00
`define CFSR_LOG_TMR 5'h01
`define CFSR_LOG_FLYCAP 5'h02
`define CFSR_LOG_OT 5'h03
`define CFSR_LOG_UV 5'h04
`define CFSR_LOG_OV 5'h05
`define CFSR_LOG_OC 5'h06
`define CFSR_LOG_CB 5'h07
`define CFSR_LOG_PG 5'h08
`define CFSR_LOG_WD 5'h14

// Bus-stuck timeout
`define CFSR_CLK_HZ 64'd50000000
`define CFSR_SCL_LOW_MS 64'd35
`define CFSR_SCL_LOW_CYC (`CFSR_SCL_LOW_MS * `CFSR_CLK_HZ / 64'd1000)

`endif

// [cfsr_first_log.sv]
// First-event logger: keeps the code of the earliest fault until reset
`timescale 1ns/1ps
`default_nettype none
`include "cfsr_cfg.svh"
module cfsr_first_log (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [8:0] ev,
    output logic [4:0] code_ff
);
    typedef struct packed {
        logic [4:0] code;
    } cfsr_log_st_t;

    cfsr_log_st_t q_ff;
    cfsr_log_st_t nxt_q;

    // Bit order of ev: timer, flycap, ot, uv, ov, oc, cboot, pg, watchdog
    function automatic logic [4:0] code_of(input int unsigned idx);
        case (idx)
            0: code_of = `CFSR_LOG_TMR;
            1: code_of = `CFSR_LOG_FLYCAP;
            2: code_of = `CFSR_LOG_OT;
            3: code_of = `CFSR_LOG_UV;
            4: code_of = `CFSR_LOG_OV;
            5: code_of = `CFSR_LOG_OC;
            6: code_of = `CFSR_LOG_CB;
            7: code_of = `CFSR_LOG_PG;
            default: code_of = `CFSR_LOG_WD;
        endcase
    endfunction

    always_comb begin
        nxt_q = q_ff;
        // Only the first capture sticks; simultaneous events take lowest code
        if (q_ff.code == `CFSR_LOG_NONE) begin // R21
            for (int i = 8; i >= 0; i--) begin
                if (ev[i]) begin
                    nxt_q.code = code_of(i); // R20
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q_ff <= '{code: `CFSR_LOG_NONE};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign code_ff = q_ff.code;
endmodule // cfsr_first_log
`default_nettype wire

// [cfsr_host.sv]
// Host-side register master model for the internal strobe port
`timescale 1ns/1ps
`default_nettype none
module cfsr_host (
    input wire logic sys_clk,
    output cfsr_pkg::cfsr_req_t reg_req,
    input wire cfsr_pkg::cfsr_rsp_t reg_rsp
);
    initial reg_req = '0;

    // Released lines show the inverse, not a stale copy of the request
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge sys_clk);
        #1;
        reg_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        #1;
        reg_req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge sys_clk);
        #1;
        reg_req = '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hFF};
        d = reg_rsp.rvalid ? reg_rsp.rdata : 8'hXX;
    endtask
endmodule // cfsr_host
`default_nettype wire

// [cfsr_pkg.sv]
// Types shared by the fault/status register bank
`default_nettype none
package cfsr_pkg;

typedef struct packed {
    logic [15:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
} cfsr_req_t;

typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
} cfsr_rsp_t;

typedef struct packed {
    logic ov;
    logic uv;
    logic ot;
    logic oc;
    logic cboot;
    logic wd_to;
    logic timer;
    logic flycap;
} cfsr_faults_t;

typedef struct packed {
    logic pin_is_pg;
    logic multiply_on;
    logic en_resolved;
    logic switching;
    logic bypass;
    logic reverse;
    logic [1:0] pg_ok;
} cfsr_opstate_t;

typedef enum logic [2:0] {
    CFSR_SW_IDLE = 3'b001,
    CFSR_SW_COUNT = 3'b010,
    CFSR_SW_FIRED = 3'b100
} cfsr_sw_state_t;

typedef struct packed {
    logic style;
    logic dither;
    logic drn_en;
    logic drn_val;
    logic drain_out;
    logic [7:0] fevt;
    logic [7:0] sevt;
    logic to_en;
    logic [6:0] addr;
    cfsr_rsp_t rsp;
} cfsr_regs_t;

endpackage
`default_nettype wire

// [cfsr_regs.sv]
// Converter fault, status and configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "cfsr_cfg.svh"
// Behaviour
// R1 - Style bit: 0 pulse extend, 1 skip
// R2 - Bit 1 enables light-load dither
// R3 - Bit 1 enables drain override, reset off
// R4 - Override on: bit 0 forces drain level
// R5 - Flags sticky; writing one clears them
// R6 - Overvolt, undervolt, overtemp, overcurrent flags latched
// R7 - Bootstrap low sets event bit 3
// R8 - Watchdog expiry sets system bit 7
// R9 - Any reset sets system bit 6
// R10 - Timer bit 2, flycap short bit 1
// R11 - Power-good loss only while switching/bypass
// R12 - Live fault status bits 7..3
// R13 - Live watchdog bit 7, timer bit 2
// R14 - Bit 0: active and comparator deasserted
// R15 - Bit 7 shows shared pin function
// R16 - Bit 6 shows multiply active
// R17 - Bit 5 shows resolved enable
// R18 - Bit 4: switching 1, bypass 0
// R19 - Bit 3: forward 0, reverse 1
// R20 - Logger records first event code
// R21 - Logger keeps first code until reset
// R22 - Clock low too long resets interface
// R23 - Seven-bit target address, default 70h
// R24 - Host writes address last before programming
module cfsr_regs #(
    parameter int unsigned SCL_LOW_CYC = int'(`CFSR_SCL_LOW_CYC)
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire cfsr_pkg::cfsr_req_t reg_req,
    output cfsr_pkg::cfsr_rsp_t reg_rsp,
    input wire cfsr_pkg::cfsr_faults_t faults,
    input wire cfsr_pkg::cfsr_opstate_t opstate,
    input wire logic host_reset_evt,
    input wire logic auto_drain,
    input wire logic scl_in,
    output logic light_load_style_sel,
    output logic light_load_dither_on,
    output logic low_side_drain,
    output logic [6:0] target_addr,
    output logic i2c_if_reset
);
    cfsr_pkg::cfsr_regs_t q_ff;
    cfsr_pkg::cfsr_regs_t nxt_q;
    logic [4:0] log_code;
    logic power_good_loss_live;
    logic [8:0] log_ev;
    logic [7:0] fault_set;
    logic [7:0] sys_set;
    logic [7:0] live_fault;
    logic [7:0] live_sys;
    logic [7:0] op_view;

    function automatic logic hit(input cfsr_pkg::cfsr_req_t r,
                                 input logic [15:0] ofs);
        hit = r.addr == ofs;
    endfunction

    // Set beats clear so an event landing with the clear is kept
    function automatic logic [7:0] w1c_upd(input logic [7:0] cur,
                                           input logic [7:0] set,
                                           input logic [7:0] clr,
                                           input logic [7:0] mask);
        w1c_upd = ((cur & ~clr) | set) & mask;
    endfunction

    // Detection window of the power-good loss
    assign power_good_loss_live = (opstate.switching | opstate.bypass)
        & (opstate.pg_ok != `CFSR_PG_ALL_OK); // R11 R14

    always_comb begin
        fault_set = 8'h00;
        fault_set[`CFSR_B_FE_OV] = faults.ov; // R6
        fault_set[`CFSR_B_FE_UV] = faults.uv; // R6
        fault_set[`CFSR_B_FE_OT] = faults.ot; // R6
        fault_set[`CFSR_B_FE_OC] = faults.oc; // R6
        fault_set[`CFSR_B_FE_CB] = faults.cboot; // R7
        sys_set = 8'h00;
        sys_set[`CFSR_B_SE_WD] = faults.wd_to; // R8
        sys_set[`CFSR_B_SE_RST] = host_reset_evt; // R9
        sys_set[`CFSR_B_SE_TMR] = faults.timer; // R10
        sys_set[`CFSR_B_SE_FLYCAP] = faults.flycap; // R10
        sys_set[`CFSR_B_SE_PG] = power_good_loss_live; // R11
    end

    always_comb begin
        live_fault = 8'h00;
        live_fault[`CFSR_B_FL_OC] = faults.oc; // R12
        live_fault[`CFSR_B_FL_OV] = faults.ov; // R12
        live_fault[`CFSR_B_FL_UV] = faults.uv; // R12
        live_fault[`CFSR_B_FL_OT] = faults.ot; // R12
        live_fault[`CFSR_B_FL_CB] = faults.cboot; // R12
        live_sys = 8'h00;
        live_sys[`CFSR_B_SE_WD] = faults.wd_to; // R13
        live_sys[`CFSR_B_SE_TMR] = faults.timer; // R13
        live_sys[`CFSR_B_SE_PG] = power_good_loss_live; // R14
        op_view = 8'h00;
        op_view[`CFSR_B_OP_PIN] = opstate.pin_is_pg; // R15
        op_view[`CFSR_B_OP_MUL] = opstate.multiply_on; // R16
        op_view[`CFSR_B_OP_EN] = opstate.en_resolved; // R17
        // Bypass reads 0 even if both inputs glitch high together
        op_view[`CFSR_B_OP_SW] = opstate.switching & ~opstate.bypass; // R18
        op_view[`CFSR_B_OP_DIR] = opstate.reverse; // R19
    end

    // Logger inputs in code order; watchdog last
    assign log_ev = {faults.wd_to, power_good_loss_live, faults.cboot,
                     faults.oc, faults.ov, faults.uv, faults.ot,
                     faults.flycap, faults.timer};

    always_comb begin
        logic wr_f;
        logic wr_s;
        wr_f = 1'b0;
        wr_s = 1'b0;
        nxt_q = q_ff;
        wr_f = reg_req.wr && hit(reg_req, `CFSR_OFS_FEVT);
        wr_s = reg_req.wr && hit(reg_req, `CFSR_OFS_SEVT);
        nxt_q.fevt = w1c_upd(q_ff.fevt, fault_set,
                             wr_f ? reg_req.wdata : 8'h00,
                             `CFSR_FEVT_MASK); // R5
        nxt_q.sevt = w1c_upd(q_ff.sevt, sys_set,
                             wr_s ? reg_req.wdata : 8'h00,
                             `CFSR_SEVT_MASK); // R5

        if (reg_req.wr && hit(reg_req, `CFSR_OFS_LLOAD)) begin
            nxt_q.style = reg_req.wdata[`CFSR_B_STYLE]; // R1
            nxt_q.dither = reg_req.wdata[`CFSR_B_DITHER]; // R2
        end
        if (reg_req.wr && hit(reg_req, `CFSR_OFS_CTRL)) begin
            nxt_q.drn_en = reg_req.wdata[`CFSR_B_DRN_EN]; // R3
            nxt_q.drn_val = reg_req.wdata[`CFSR_B_DRN_VAL]; // R4
        end
        // Address change takes effect for the next transfer
        if (reg_req.wr && hit(reg_req, `CFSR_OFS_ADDR)) begin
            nxt_q.to_en = reg_req.wdata[`CFSR_B_TO_EN]; // R22
            nxt_q.addr = reg_req.wdata[`CFSR_ADDR_MSB:0]; // R23
        end

        // Automatic discharge passes through unless overridden
        nxt_q.drain_out = q_ff.drn_en ? q_ff.drn_val : auto_drain; // R4

        nxt_q.rsp.rvalid = reg_req.rd;
        nxt_q.rsp.rdata = `CFSR_RST_BYTE;
        if (reg_req.rd) begin
            case (reg_req.addr)
                `CFSR_OFS_LLOAD: begin
                    nxt_q.rsp.rdata[`CFSR_B_STYLE] = q_ff.style;
                    nxt_q.rsp.rdata[`CFSR_B_DITHER] = q_ff.dither;
                end
                `CFSR_OFS_CTRL: begin
                    nxt_q.rsp.rdata[`CFSR_B_DRN_EN] = q_ff.drn_en;
                    nxt_q.rsp.rdata[`CFSR_B_DRN_VAL] = q_ff.drn_val;
                end
                `CFSR_OFS_FEVT: nxt_q.rsp.rdata = q_ff.fevt;
                `CFSR_OFS_SEVT: nxt_q.rsp.rdata = q_ff.sevt;
                `CFSR_OFS_FLIVE: nxt_q.rsp.rdata = live_fault; // R12
                `CFSR_OFS_SLIVE: nxt_q.rsp.rdata = live_sys; // R13
                `CFSR_OFS_OPST: nxt_q.rsp.rdata = op_view;
                // Watchdog code needs a fifth bit; upper bits stay zero
                `CFSR_OFS_LOG: nxt_q.rsp.rdata = {3'h0, log_code}; // R20
                `CFSR_OFS_ADDR: begin
                    nxt_q.rsp.rdata = {q_ff.to_en, q_ff.addr};
                end
                default: nxt_q.rsp.rdata = `CFSR_RST_BYTE;
            endcase
        end
    end

    // Reset-seen flag comes up set, so a power-on is reported too
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q_ff <= '{style: 1'b0, dither: 1'b0, drn_en: 1'b0,
                      drn_val: 1'b0, drain_out: 1'b0,
                      fevt: `CFSR_RST_FEVT, sevt: `CFSR_RST_SEVT, // R9
                      to_en: 1'b0, addr: `CFSR_RST_ADDR, // R23
                      rsp: '{rdata: `CFSR_RST_BYTE, rvalid: 1'b0}};
        end else begin
            q_ff <= nxt_q;
        end
    end

    cfsr_first_log u_first_log (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .ev(log_ev),
        .code_ff(log_code)
    );

    cfsr_scl_watch #(
        .LIMIT(SCL_LOW_CYC)
    ) u_scl_watch (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .enable(q_ff.to_en),
        .scl_in(scl_in),
        .fire_ff(i2c_if_reset)
    );

    assign reg_rsp = q_ff.rsp;
    assign light_load_style_sel = q_ff.style;
    assign light_load_dither_on = q_ff.dither;
    assign low_side_drain = q_ff.drain_out;
    assign target_addr = q_ff.addr;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);

    logic wr_ov_clr;
    assign wr_ov_clr = reg_req.wr && hit(reg_req, `CFSR_OFS_FEVT)
        && reg_req.wdata[`CFSR_B_FE_OV];

    property p_flag_sticky;
        q_ff.fevt[`CFSR_B_FE_OV] && !wr_ov_clr |=> q_ff.fevt[`CFSR_B_FE_OV];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) // R5
        else $error("overvolt flag dropped without a clear");

    property p_flag_clear;
        wr_ov_clr && !faults.ov |=> !q_ff.fevt[`CFSR_B_FE_OV];
    endproperty
    a_flag_clear: assert property (p_flag_clear) // R5
        else $error("write one did not clear overvolt flag");

    property p_fault_latch;
        faults.uv || faults.oc
            |=> (q_ff.fevt[`CFSR_B_FE_UV] || !$past(faults.uv))
            && (q_ff.fevt[`CFSR_B_FE_OC] || !$past(faults.oc));
    endproperty
    a_fault_latch: assert property (p_fault_latch) // R6
        else $error("fault condition not latched");

    property p_boot_latch;
        faults.cboot ##1 !faults.cboot |-> q_ff.fevt[`CFSR_B_FE_CB];
    endproperty
    a_boot_latch: assert property (p_boot_latch) // R7
        else $error("bootstrap flag not set");

    property p_reset_seen;
        host_reset_evt |=> q_ff.sevt[`CFSR_B_SE_RST];
    endproperty
    a_reset_seen: assert property (p_reset_seen) // R9
        else $error("reset seen flag not set");

    property p_pg_window;
        !opstate.switching && !opstate.bypass && !q_ff.sevt[`CFSR_B_SE_PG]
            |=> !q_ff.sevt[`CFSR_B_SE_PG];
    endproperty
    a_pg_window: assert property (p_pg_window) // R11
        else $error("power-good loss flagged outside active states");

    property p_drain_force;
        q_ff.drn_en ##1 q_ff.drn_en |-> low_side_drain == $past(q_ff.drn_val);
    endproperty
    a_drain_force: assert property (p_drain_force) // R4
        else $error("forced drain level not applied");

    property p_live_read;
        reg_req.rd && hit(reg_req, `CFSR_OFS_FLIVE) |=> reg_rsp.rvalid
            && reg_rsp.rdata[`CFSR_B_FL_OC] == $past(faults.oc);
    endproperty
    a_live_read: assert property (p_live_read) // R12
        else $error("live overcurrent read wrong");

    property p_op_read;
        reg_req.rd && hit(reg_req, `CFSR_OFS_OPST) && opstate.bypass
            |=> !reg_rsp.rdata[`CFSR_B_OP_SW]
            && reg_rsp.rdata[`CFSR_B_OP_DIR] == $past(opstate.reverse);
    endproperty
    a_op_read: assert property (p_op_read) // R18
        else $error("operating state read wrong");

    property p_log_hold;
        log_code != `CFSR_LOG_NONE |=> $stable(log_code);
    endproperty
    a_log_hold: assert property (p_log_hold) // R21
        else $error("first event code overwritten");

    property p_log_catch;
        log_code == `CFSR_LOG_NONE && faults.timer
            |=> log_code == `CFSR_LOG_TMR;
    endproperty
    a_log_catch: assert property (p_log_catch) // R20
        else $error("timer event not logged with code 1");

    property p_to_gate;
        i2c_if_reset |-> $past(q_ff.to_en) && !$past(scl_in);
    endproperty
    a_to_gate: assert property (p_to_gate) // R22
        else $error("interface reset without enabled timeout");

    c_flag_cleared: cover property (q_ff.fevt[`CFSR_B_FE_OV] ##1
        !q_ff.fevt[`CFSR_B_FE_OV]);
    c_logged: cover property (log_code == `CFSR_LOG_WD);
    c_if_reset: cover property (i2c_if_reset);
    c_addr_moved: cover property (target_addr != `CFSR_RST_ADDR);
endmodule // cfsr_regs
`default_nettype wire

// [cfsr_regs_tb.sv]
// Self-checking bench for the converter fault and status bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin \
    compares++; \
    if ((g) !== (e)) begin \
        fails++; \
        $display("mismatch %s exp %h got %h", n, e, g); \
    end \
end
module cfsr_regs_tb;
    logic sys_clk;
    logic nrst;
    cfsr_pkg::cfsr_req_t reg_req;
    cfsr_pkg::cfsr_rsp_t reg_rsp;
    cfsr_pkg::cfsr_faults_t faults;
    cfsr_pkg::cfsr_opstate_t opstate;
    logic host_reset_evt;
    logic auto_drain;
    logic scl_in;
    logic light_load_style_sel;
    logic light_load_dither_on;
    logic low_side_drain;
    logic [6:0] target_addr;
    logic i2c_if_reset;
    int fails;
    int compares;

    // Short bus-stuck limit keeps the run brief
    cfsr_regs #(.SCL_LOW_CYC(20)) dut (.sys_clk, .nrst, .reg_req,
        .reg_rsp, .faults, .opstate, .host_reset_evt, .auto_drain, .scl_in,
        .light_load_style_sel, .light_load_dither_on, .low_side_drain,
        .target_addr, .i2c_if_reset);
    cfsr_host h (.sys_clk, .reg_req, .reg_rsp);

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic rc(input logic [15:0] a, input logic [7:0] e,
                      input string n);
        logic [7:0] d;
        h.rd(a, d);
        `CHK(n, e, d)
    endtask

    task automatic fin(input string n);
        $display("test %s done, %0d mismatches so far", n, fails);
    endtask

    task automatic t_rst();
        logic [15:0] a [9];
        logic [7:0] e [9];
        a = '{16'h001C, 16'h001D, 16'h0022, 16'h0023, 16'h0024,
              16'h0025, 16'h0026, 16'h0027, 16'h0039};
        e = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00,
              8'h00, 8'h00, 8'h00, 8'h70};
        for (int i = 0; i < 9; i++) begin
            rc(a[i], e[i], "reset_val");
        end
        fin("reset");
    endtask

    task automatic t_cfg();
        h.wr(16'h001C, 8'h0A);
        rc(16'h001C, 8'h0A, "lload");
        `CHK("style", 1'b1, light_load_style_sel)
        `CHK("dither", 1'b1, light_load_dither_on)
        h.wr(16'h001C, 8'h08);
        tick(1);
        `CHK("dither_off", 1'b0, light_load_dither_on)
        for (int i = 0; i < 8; i++) begin
            auto_drain = i[2];
            h.wr(16'h001D, {6'h00, i[1:0]});
            tick(2);
            `CHK("drain", i[1] ? i[0] : i[2], low_side_drain)
        end
        fin("config");
    endtask

    task automatic t_fault();
        logic [7:0] f;
        for (int i = 3; i < 8; i++) begin
            f = 8'h01 << i;
            faults = f;
            rc(16'h0024, {f[4], f[7:5], f[3], 3'h0}, "live");
            faults = '0;
            rc(16'h0022, f, "event");
            h.wr(16'h0022, 8'h00);
            rc(16'h0022, f, "sticky");
            h.wr(16'h0022, f);
            rc(16'h0022, 8'h00, "clear");
        end
        // Bootstrap came first, later faults must not overwrite it
        rc(16'h0027, 8'h07, "first");
        fin("fault");
    endtask

    task automatic t_sys();
        logic [7:0] lv [3];
        logic [7:0] ev [3];
        lv = '{8'h80, 8'h04, 8'h00};
        ev = '{8'h80, 8'h04, 8'h02};
        h.wr(16'h0023, 8'h40);
        rc(16'h0023, 8'h00, "reset_clr");
        for (int i = 0; i < 3; i++) begin
            faults = 8'h04 >> i;
            rc(16'h0025, lv[i], "sys_live");
            faults = '0;
            rc(16'h0023, ev[i], "sys_event");
            h.wr(16'h0023, ev[i]);
        end
        // Comparator low while idle is no fault
        opstate = 8'h01;
        rc(16'h0025, 8'h00, "pg_idle_live");
        rc(16'h0023, 8'h00, "pg_idle");
        opstate = 8'h11;
        rc(16'h0025, 8'h01, "pg_live");
        opstate = 8'h03;
        rc(16'h0023, 8'h01, "pg_event");
        h.wr(16'h0023, 8'h01);
        host_reset_evt = 1'b1;
        tick(1);
        host_reset_evt = 1'b0;
        rc(16'h0023, 8'h40, "host_reset");
        fin("system");
    endtask

    task automatic t_opst();
        logic [7:0] o [4];
        logic [7:0] e;
        o = '{8'hF7, 8'h5B, 8'hA7, 8'h13};
        for (int i = 0; i < 4; i++) begin
            opstate = o[i];
            e = {o[i][7:5], o[i][4] & ~o[i][3], o[i][2], 3'h0};
            rc(16'h0026, e, "opstate");
        end
        opstate = 8'h03;
        fin("opstate");
    endtask

    task automatic t_addr();
        int n;
        rc(16'h0100, 8'h00, "unmapped");
        h.wr(16'h0039, 8'hB5);
        rc(16'h0039, 8'hB5, "addr_wr");
        `CHK("addr_pin", 7'h35, target_addr)
        n = 0;
        scl_in = 1'b0;
        for (int i = 0; i < 60; i++) begin
            tick(1);
            n += i2c_if_reset;
        end
        `CHK("stuck_fire", 1, n)
        scl_in = 1'b1;
        h.wr(16'h0039, 8'h70);
        `CHK("addr_back", 7'h70, target_addr)
        n = 0;
        scl_in = 1'b0;
        for (int i = 0; i < 60; i++) begin
            tick(1);
            n += i2c_if_reset;
        end
        scl_in = 1'b1;
        `CHK("stuck_off", 0, n)
        fin("address");
    endtask

    task automatic t_rerst();
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        rc(16'h0027, 8'h00, "log_cleared");
        rc(16'h0023, 8'h40, "reset_again");
        faults = 8'h04;
        tick(1);
        faults = 8'h02;
        tick(1);
        faults = '0;
        rc(16'h0027, 8'h14, "log_wd");
        // Watchdog and timer together: the lower code is kept
        nrst = 1'b0;
        tick(2);
        nrst = 1'b1;
        faults = 8'h06;
        tick(1);
        faults = '0;
        rc(16'h0027, 8'h01, "log_both");
        fin("rereset");
    endtask

    task automatic test_done();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    initial begin
        fails = 0;
        compares = 0;
        nrst = 1'b0;
        faults = '0;
        opstate = 8'h03;
        host_reset_evt = 1'b0;
        auto_drain = 1'b0;
        scl_in = 1'b1;
        tick(2);
        nrst = 1'b1;
        t_rst();
        t_cfg();
        t_fault();
        t_sys();
        t_opst();
        t_addr();
        t_rerst();
        test_done();
    end

    // Hang guard
    initial begin
        #2000000;
        fails++;
        test_done();
    end
endmodule // cfsr_regs_tb
`default_nettype wire

// [cfsr_scl_watch.sv]
// Clock-line stuck-low watchdog for the serial interface
`timescale 1ns/1ps
`default_nettype none
module cfsr_scl_watch #(
    parameter int unsigned LIMIT = 1750000,
    parameter int unsigned CW = $clog2(LIMIT + 1)
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic enable,
    input wire logic scl_in,
    output logic fire_ff
);
    localparam logic [CW-1:0] LIM = CW'(LIMIT);

    typedef struct packed {
        cfsr_pkg::cfsr_sw_state_t st;
        logic [CW-1:0] cnt;
        logic fire;
    } cfsr_sw_st_t;

    cfsr_sw_st_t q_ff;
    cfsr_sw_st_t nxt_q;

    always_comb begin
        nxt_q = q_ff;
        nxt_q.fire = 1'b0;
        if (!enable || scl_in) begin
            nxt_q.st = cfsr_pkg::CFSR_SW_IDLE;
            nxt_q.cnt = '0;
        end else begin
            unique case (q_ff.st)
                cfsr_pkg::CFSR_SW_IDLE: begin
                    nxt_q.st = cfsr_pkg::CFSR_SW_COUNT;
                    nxt_q.cnt = {{(CW-1){1'b0}}, 1'b1};
                end
                cfsr_pkg::CFSR_SW_COUNT: begin
                    // Low strictly longer than the limit before firing
                    if (q_ff.cnt == LIM) begin // R22
                        nxt_q.fire = 1'b1;
                        nxt_q.st = cfsr_pkg::CFSR_SW_FIRED;
                    end else begin
                        nxt_q.cnt = q_ff.cnt + 1'b1;
                    end
                end
                cfsr_pkg::CFSR_SW_FIRED: begin
                    nxt_q.st = cfsr_pkg::CFSR_SW_FIRED;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            q_ff <= '{st: cfsr_pkg::CFSR_SW_IDLE, cnt: '0, fire: 1'b0};
        end else begin
            q_ff <= nxt_q;
        end
    end

    assign fire_ff = q_ff.fire;
endmodule // cfsr_scl_watch
`default_nettype wire
